// *** design/audio_fifo_consts.svh ***
`ifndef AUDIO_FIFO_CONSTS_SVH
`define AUDIO_FIFO_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CFG_OFS 12'he00
`define STAT_OFS 12'he04
`define TRIG_OFS 12'he08
`define IRQ_STAT_OFS 12'he0c
`define IRQ_MASK_OFS 12'he10
`define TX_DATA_OFS 12'he20
`define RX_DATA_OFS 12'he30

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define CFG_TX_DMA_BIT 12
`define CFG_RX_DMA_BIT 13
`define CFG_TX_WAKE_BIT 14
`define CFG_RX_WAKE_BIT 15
`define CFG_TX_FLUSH_BIT 16
`define CFG_RX_FLUSH_BIT 17

// ----------------------------------------
// Status fields
// ----------------------------------------
`define STAT_TX_EMPTY_BIT 4
`define STAT_TX_NOT_FULL_BIT 5
`define STAT_RX_NOT_EMPTY_BIT 6
`define STAT_RX_FULL_BIT 7
`define STAT_TX_LVL_LSB 8
`define STAT_RX_LVL_LSB 16

// ----------------------------------------
// Trigger settings fields
// ----------------------------------------
`define TRIG_TX_ENA_BIT 0
`define TRIG_RX_ENA_BIT 1
`define TRIG_TX_LVL_LSB 8
`define TRIG_RX_LVL_LSB 16

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define IRQ_TX_ERR 0
`define IRQ_RX_ERR 1
`define IRQ_TX_LVL 2
`define IRQ_RX_LVL 3

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define FIFO_DEPTH 8
`define LVL_FULL 4'h8
`define LVL_ZERO 4'h0
`define PTR_ZERO 3'h0
`define PTR_ONE 3'h1
`define LVL_ONE 4'h1
`define WORD_ZERO 32'h0000_0000
`define IRQ_ZERO 4'h0

`endif

// *** design/audio_fifo_pkg.sv ***
`default_nettype none

package audio_fifo_pkg;
   typedef logic [11:0] addr_t;
   typedef logic [31:0] word_t;
   typedef logic [3:0] lvl_t;
   typedef logic [2:0] ptr_t;
   typedef logic [3:0] irq_t;
endpackage

`default_nettype wire

// *** design/fifo_if.sv ***
`default_nettype none

interface fifo_if;
   import audio_fifo_pkg::*;
   logic push;
   word_t push_data;
   logic pop;
   logic flush;
   word_t pop_data;
   lvl_t level;
   logic full;
   logic empty;
   modport ctrl (output push, output push_data, output pop, output flush,
                 input pop_data, input level, input full, input empty);
   modport store (input push, input push_data, input pop, input flush,
                  output pop_data, output level, output full, output empty);
endinterface

`default_nettype wire

// *** design/fifo_store.sv ***
`include "audio_fifo_consts.svh"
`default_nettype none

module fifo_store (
   input wire logic clk_sys,
   input wire logic rst,
   fifo_if.store fifo
);
   import audio_fifo_pkg::*;

   ptr_t wr_ptr_reg, wr_ptr_next;
   ptr_t rd_ptr_reg, rd_ptr_next;
   lvl_t level_reg, level_next;
   word_t pop_data_reg, pop_data_next;
   word_t mem [0:`FIFO_DEPTH-1];
   logic do_push;
   logic do_pop;

   // Flags from the occupancy count
   assign fifo.full = (level_reg == `LVL_FULL);
   assign fifo.empty = (level_reg == `LVL_ZERO);
   assign fifo.level = level_reg;
   assign fifo.pop_data = pop_data_reg;

   // Pointer and level update; flush beats push and pop
   always_comb begin
      do_push = fifo.push && !fifo.full && !fifo.flush;
      do_pop = fifo.pop && !fifo.empty && !fifo.flush;
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      level_next = level_reg;
      pop_data_next = pop_data_reg;
      if (fifo.flush) begin
         wr_ptr_next = `PTR_ZERO;
         rd_ptr_next = `PTR_ZERO;
         level_next = `LVL_ZERO;
      end else begin
         if (do_push) begin
            wr_ptr_next = wr_ptr_reg + `PTR_ONE;
         end
         if (do_pop) begin
            rd_ptr_next = rd_ptr_reg + `PTR_ONE;
            pop_data_next = mem[rd_ptr_reg];
         end
         if (do_push && !do_pop) begin
            level_next = level_reg + `LVL_ONE;
         end else if (do_pop && !do_push) begin
            level_next = level_reg - `LVL_ONE;
         end
      end
   end

   // State registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_ptr_reg <= `PTR_ZERO;
         rd_ptr_reg <= `PTR_ZERO;
         level_reg <= `LVL_ZERO;
         pop_data_reg <= `WORD_ZERO;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         level_reg <= level_next;
         pop_data_reg <= pop_data_next;
      end
   end

   // Storage array, no reset
   always_ff @(posedge clk_sys) begin
      if (do_push) begin
         mem[wr_ptr_reg] <= fifo.push_data;
      end
   end
endmodule

`default_nettype wire

// *** design/audio_fifo_dma_wake_flush_ctrl.sv ***
// Added by the designer: the plain strobed port.
`include "audio_fifo_consts.svh"
`default_nettype none

module audio_fifo_dma_wake_flush_ctrl (
   input wire logic clk_sys,
   input wire logic rst,
   input wire audio_fifo_pkg::addr_t addr,
   input wire audio_fifo_pkg::word_t wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   input wire logic tx_pop,
   output logic [31:0] tx_word,
   input wire logic rx_push,
   input wire audio_fifo_pkg::word_t rx_word,
   output logic tx_dma_req,
   output logic rx_dma_req,
   output logic dma_wake_req,
   output logic irq
);
   import audio_fifo_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   // Software-visible state, read path and wake registers
   logic tx_dma_sel_reg, tx_dma_sel_next;
   logic rx_dma_sel_reg, rx_dma_sel_next;
   logic tx_wake_sel_reg, tx_wake_sel_next;
   logic rx_wake_sel_reg, rx_wake_sel_next;
   logic tx_lvl_ena_reg, tx_lvl_ena_next;
   logic rx_lvl_ena_reg, rx_lvl_ena_next;
   lvl_t tx_trigger_level_reg, tx_trigger_level_next;
   lvl_t rx_trigger_level_reg, rx_trigger_level_next;
   irq_t irq_stat_reg, irq_stat_next;
   irq_t irq_mask_reg, irq_mask_next;
   word_t rd_data_reg, rd_data_next;
   logic rd_rx_sel_reg, rd_rx_sel_next;
   logic tx_wake_reg, tx_wake_next;
   logic rx_wake_reg, rx_wake_next;
   // Decoded commands, events and the status word
   logic tx_flush_cmd;
   logic rx_flush_cmd;
   logic tx_level_hit;
   logic rx_level_hit;
   logic tx_overflow;
   logic rx_overflow;
   logic tx_underflow;
   irq_t irq_event;
   word_t stat_word;

   // Carriers to the two FIFOs
   fifo_if tx_if ();
   fifo_if rx_if ();

   // ----------------------------------------
   // FIFO storage
   // ----------------------------------------
   fifo_store tx_store (
      .clk_sys(clk_sys),
      .rst(rst),
      .fifo(tx_if.store)
   );

   fifo_store rx_store (
      .clk_sys(clk_sys),
      .rst(rst),
      .fifo(rx_if.store)
   );

   // ----------------------------------------
   // Bus decode and data paths
   // ----------------------------------------
   // Flush commands act only on a written one
   assign tx_flush_cmd = wr_en && (addr == `CFG_OFS) && wr_data[`CFG_TX_FLUSH_BIT];
   assign rx_flush_cmd = wr_en && (addr == `CFG_OFS) && wr_data[`CFG_RX_FLUSH_BIT];

   // Transmit side: bus writes push, serializer pops
   assign tx_if.push = wr_en && (addr == `TX_DATA_OFS);
   assign tx_if.push_data = wr_data;
   assign tx_if.pop = tx_pop;
   assign tx_if.flush = tx_flush_cmd;
   assign tx_word = tx_if.pop_data;

   // Receive side: deserializer pushes, bus reads pop
   assign rx_if.push = rx_push;
   assign rx_if.push_data = rx_word;
   assign rx_if.pop = rd_en && (addr == `RX_DATA_OFS);
   assign rx_if.flush = rx_flush_cmd;

   // ----------------------------------------
   // DMA requests and level compare
   // ----------------------------------------
   // Requests follow occupancy directly
   assign tx_dma_req = tx_dma_sel_reg && !tx_if.full;
   assign rx_dma_req = rx_dma_sel_reg && !rx_if.empty;

   // Level equals trigger level from the trigger settings
   assign tx_level_hit = (tx_if.level == tx_trigger_level_reg);
   assign rx_level_hit = (rx_if.level == rx_trigger_level_reg);

   // ----------------------------------------
   // Level wake
   // ----------------------------------------
   // Wake request to the DMA wake path only, independent of interrupt masks
   assign dma_wake_req = tx_wake_reg || rx_wake_reg;

   // Wake levels, registered
   always_comb begin
      tx_wake_next = tx_wake_sel_reg && tx_level_hit;
      rx_wake_next = rx_wake_sel_reg && rx_level_hit;
   end

   // Wake registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_wake_reg <= 1'b0;
         rx_wake_reg <= 1'b0;
      end else begin
         tx_wake_reg <= tx_wake_next;
         rx_wake_reg <= rx_wake_next;
      end
   end

   // ----------------------------------------
   // Interrupt events
   // ----------------------------------------
   // Errors: push to full on either side, pop from empty on transmit only; a flush suppresses them
   assign tx_overflow = tx_if.push && tx_if.full && !tx_flush_cmd;
   assign tx_underflow = tx_pop && tx_if.empty && !tx_flush_cmd;
   assign rx_overflow = rx_push && rx_if.full && !rx_flush_cmd;

   // Event vector: errors and enabled level triggers
   always_comb begin
      irq_event = `IRQ_ZERO;
      irq_event[`IRQ_TX_ERR] = tx_overflow || tx_underflow;
      irq_event[`IRQ_RX_ERR] = rx_overflow;
      irq_event[`IRQ_TX_LVL] = tx_lvl_ena_reg && tx_level_hit;
      irq_event[`IRQ_RX_LVL] = rx_lvl_ena_reg && rx_level_hit;
   end

   // ----------------------------------------
   // Interrupt output
   // ----------------------------------------
   // High while any unmasked sticky bit is set
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // ----------------------------------------
   // Status word
   // ----------------------------------------
   // Flags, levels and masked pending bits
   always_comb begin
      stat_word = `WORD_ZERO;
      stat_word[`IRQ_RX_LVL:`IRQ_TX_ERR] = irq_stat_reg & irq_mask_reg;
      stat_word[`STAT_TX_EMPTY_BIT] = tx_if.empty;
      stat_word[`STAT_TX_NOT_FULL_BIT] = !tx_if.full;
      stat_word[`STAT_RX_NOT_EMPTY_BIT] = !rx_if.empty;
      stat_word[`STAT_RX_FULL_BIT] = rx_if.full;
      stat_word[`STAT_TX_LVL_LSB +: 4] = tx_if.level;
      stat_word[`STAT_RX_LVL_LSB +: 4] = rx_if.level;
   end

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   // Next values for software-visible registers
   always_comb begin
      tx_dma_sel_next = tx_dma_sel_reg;
      rx_dma_sel_next = rx_dma_sel_reg;
      tx_wake_sel_next = tx_wake_sel_reg;
      rx_wake_sel_next = rx_wake_sel_reg;
      tx_lvl_ena_next = tx_lvl_ena_reg;
      rx_lvl_ena_next = rx_lvl_ena_reg;
      tx_trigger_level_next = tx_trigger_level_reg;
      rx_trigger_level_next = rx_trigger_level_reg;
      irq_mask_next = irq_mask_reg;
      irq_stat_next = irq_stat_reg;
      if (wr_en) begin
         case (addr)
            `CFG_OFS: begin
               tx_dma_sel_next = wr_data[`CFG_TX_DMA_BIT];
               rx_dma_sel_next = wr_data[`CFG_RX_DMA_BIT];
               tx_wake_sel_next = wr_data[`CFG_TX_WAKE_BIT];
               rx_wake_sel_next = wr_data[`CFG_RX_WAKE_BIT];
            end
            `TRIG_OFS: begin
               tx_lvl_ena_next = wr_data[`TRIG_TX_ENA_BIT];
               rx_lvl_ena_next = wr_data[`TRIG_RX_ENA_BIT];
               tx_trigger_level_next = wr_data[`TRIG_TX_LVL_LSB +: 4];
               rx_trigger_level_next = wr_data[`TRIG_RX_LVL_LSB +: 4];
            end
            `IRQ_STAT_OFS: begin
               irq_stat_next = irq_stat_reg & ~wr_data[`IRQ_RX_LVL:`IRQ_TX_ERR];
            end
            `IRQ_MASK_OFS: begin
               irq_mask_next = wr_data[`IRQ_RX_LVL:`IRQ_TX_ERR];
            end
            default: begin
            end
         endcase
      end
      // New events win over a same-cycle clear
      irq_stat_next = irq_stat_next | irq_event;
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Read path, data stand one cycle after the strobe
   always_comb begin
      rd_data_next = `WORD_ZERO;
      rd_rx_sel_next = 1'b0;
      if (rd_en) begin
         case (addr)
            `CFG_OFS: begin
               // Flush bits and reserved bits read zero
               rd_data_next[`CFG_TX_DMA_BIT] = tx_dma_sel_reg;
               rd_data_next[`CFG_RX_DMA_BIT] = rx_dma_sel_reg;
               rd_data_next[`CFG_TX_WAKE_BIT] = tx_wake_sel_reg;
               rd_data_next[`CFG_RX_WAKE_BIT] = rx_wake_sel_reg;
            end
            `STAT_OFS: begin
               rd_data_next = stat_word;
            end
            `TRIG_OFS: begin
               rd_data_next[`TRIG_TX_ENA_BIT] = tx_lvl_ena_reg;
               rd_data_next[`TRIG_RX_ENA_BIT] = rx_lvl_ena_reg;
               rd_data_next[`TRIG_TX_LVL_LSB +: 4] = tx_trigger_level_reg;
               rd_data_next[`TRIG_RX_LVL_LSB +: 4] = rx_trigger_level_reg;
            end
            `IRQ_STAT_OFS: begin
               rd_data_next[`IRQ_RX_LVL:`IRQ_TX_ERR] = irq_stat_reg;
            end
            `IRQ_MASK_OFS: begin
               rd_data_next[`IRQ_RX_LVL:`IRQ_TX_ERR] = irq_mask_reg;
            end
            `RX_DATA_OFS: begin
               rd_rx_sel_next = !rx_if.empty;
            end
            default: begin
               rd_data_next = `WORD_ZERO;
            end
         endcase
      end
   end

   // Receive data come straight from the storage output register
   assign rd_data = rd_rx_sel_reg ? rx_if.pop_data : rd_data_reg;

   // ----------------------------------------
   // Flops
   // ----------------------------------------
   // Register file flops
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_dma_sel_reg <= 1'b0;
         rx_dma_sel_reg <= 1'b0;
         tx_wake_sel_reg <= 1'b0;
         rx_wake_sel_reg <= 1'b0;
         tx_lvl_ena_reg <= 1'b0;
         rx_lvl_ena_reg <= 1'b0;
         tx_trigger_level_reg <= `LVL_ZERO;
         rx_trigger_level_reg <= `LVL_ZERO;
         irq_stat_reg <= `IRQ_ZERO;
         irq_mask_reg <= `IRQ_ZERO;
      end else begin
         tx_dma_sel_reg <= tx_dma_sel_next;
         rx_dma_sel_reg <= rx_dma_sel_next;
         tx_wake_sel_reg <= tx_wake_sel_next;
         rx_wake_sel_reg <= rx_wake_sel_next;
         tx_lvl_ena_reg <= tx_lvl_ena_next;
         rx_lvl_ena_reg <= rx_lvl_ena_next;
         tx_trigger_level_reg <= tx_trigger_level_next;
         rx_trigger_level_reg <= rx_trigger_level_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   // Read path flops
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_data_reg <= `WORD_ZERO;
         rd_rx_sel_reg <= 1'b0;
      end else begin
         rd_data_reg <= rd_data_next;
         rd_rx_sel_reg <= rd_rx_sel_next;
      end
   end
endmodule

`default_nettype wire

// *** testbench/ctrl_monitor.sv ***
`include "audio_fifo_consts.svh"
`default_nettype none

module ctrl_monitor (
   input wire logic clk_sys,
   input wire logic rst,
   input wire audio_fifo_pkg::addr_t addr,
   input wire audio_fifo_pkg::word_t wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [31:0] rd_data,
   input wire logic tx_pop,
   input wire logic [31:0] tx_word,
   input wire logic rx_push,
   input wire audio_fifo_pkg::word_t rx_word,
   input wire logic tx_dma_req,
   input wire logic rx_dma_req,
   input wire logic dma_wake_req,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   import audio_fifo_pkg::*;
   // ----------------------------
   // Shadow of selects and levels
   // ----------------------------
   logic [3:0] sel_reg;
   lvl_t tx_lvl_reg, rx_lvl_reg, tx_trig_reg, rx_trig_reg;
   logic tx_in, tx_out, rx_in, rx_out, tx_flush, rx_flush, wake_cond;
   // Decoded bus and stream events
   assign tx_flush = wr_en && addr == `CFG_OFS && wr_data[`CFG_TX_FLUSH_BIT];
   assign rx_flush = wr_en && addr == `CFG_OFS && wr_data[`CFG_RX_FLUSH_BIT];
   assign tx_in = wr_en && addr == `TX_DATA_OFS && tx_lvl_reg != `LVL_FULL;
   assign tx_out = tx_pop && tx_lvl_reg != `LVL_ZERO;
   assign rx_in = rx_push && rx_lvl_reg != `LVL_FULL;
   assign rx_out = rd_en && addr == `RX_DATA_OFS && rx_lvl_reg != `LVL_ZERO;
   assign wake_cond = (sel_reg[2] && tx_lvl_reg == tx_trig_reg)
      || (sel_reg[3] && rx_lvl_reg == rx_trig_reg);
   // Registers as software sees them
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sel_reg <= 4'h0;
         tx_lvl_reg <= `LVL_ZERO;
         rx_lvl_reg <= `LVL_ZERO;
         tx_trig_reg <= `LVL_ZERO;
         rx_trig_reg <= `LVL_ZERO;
      end else begin
         if (wr_en && addr == `CFG_OFS) begin
            sel_reg <= wr_data[15:12];
         end
         if (wr_en && addr == `TRIG_OFS) begin
            tx_trig_reg <= wr_data[11:8];
            rx_trig_reg <= wr_data[19:16];
         end
         tx_lvl_reg <= tx_flush ? `LVL_ZERO : tx_lvl_reg + lvl_t'(tx_in) - lvl_t'(tx_out);
         rx_lvl_reg <= rx_flush ? `LVL_ZERO : rx_lvl_reg + lvl_t'(rx_in) - lvl_t'(rx_out);
      end
   end
   // ----------------------------
   // Properties
   // ----------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_tx_off;
      !sel_reg[0] |-> !tx_dma_req;
   endproperty
   a_tx_off: assert property (p_tx_off) else $error("tx dma req unselected");
   property p_tx_on;
      sel_reg[0] |-> tx_dma_req == (tx_lvl_reg != `LVL_FULL);
   endproperty
   a_tx_on: assert property (p_tx_on) else $error("tx dma req vs level");
   property p_rx_req;
      rx_dma_req == (sel_reg[1] && rx_lvl_reg != `LVL_ZERO);
   endproperty
   a_rx_req: assert property (p_rx_req) else $error("rx dma req vs level");
   property p_wake_tx;
      sel_reg[2] && tx_lvl_reg == tx_trig_reg |=> dma_wake_req;
   endproperty
   a_wake_tx: assert property (p_wake_tx) else $error("tx wake missing");
   property p_wake_rx;
      sel_reg[3] && rx_lvl_reg == rx_trig_reg |=> dma_wake_req;
   endproperty
   a_wake_rx: assert property (p_wake_rx) else $error("rx wake missing");
   property p_wake_off;
      !wake_cond |=> !dma_wake_req;
   endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake without cause");
   property p_tx_flush;
      tx_flush ##1 (rd_en && addr == `STAT_OFS) |=> rd_data[11:8] == `LVL_ZERO;
   endproperty
   a_tx_flush: assert property (p_tx_flush) else $error("tx flush left data");
   property p_rx_flush;
      rx_flush ##1 (rd_en && addr == `STAT_OFS) |=> rd_data[19:16] == `LVL_ZERO;
   endproperty
   a_rx_flush: assert property (p_rx_flush) else $error("rx flush left data");
   property p_cfg_rd;
      rd_en && addr == `CFG_OFS |=> rd_data == {14'h0, 2'h0, $past(sel_reg), 12'h000};
   endproperty
   a_cfg_rd: assert property (p_cfg_rd) else $error("config readback");
   c_full: cover property (sel_reg[0] && tx_lvl_reg == `LVL_FULL);
   c_wake: cover property ($rose(dma_wake_req));
   c_flush: cover property (tx_flush ##1 rd_en);
endmodule

bind audio_fifo_dma_wake_flush_ctrl ctrl_monitor mon (.clk_sys(clk_sys), .rst(rst),
   .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
   .tx_pop(tx_pop), .tx_word(tx_word), .rx_push(rx_push), .rx_word(rx_word),
   .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .dma_wake_req(dma_wake_req), .irq(irq));

`default_nettype wire

// *** testbench/link_model.sv ***
`default_nettype none

module link_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic pop_req,
   input wire logic push_req,
   output logic tx_pop,
   output logic rx_push,
   output logic [31:0] rx_word
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] count_reg;
   // Serializer and deserializer strobes, one cycle after each request
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_pop <= 1'b0;
         rx_push <= 1'b0;
         count_reg <= 32'h0000_a000;
      end else begin
         tx_pop <= pop_req;
         rx_push <= push_req;
         if (rx_push) begin
            count_reg <= count_reg + 32'h1;
         end
      end
   end
   // Word valid only beside the push strobe
   assign rx_word = rx_push ? count_reg : ~count_reg;
endmodule

`default_nettype wire

// *** testbench/audio_fifo_dma_wake_flush_ctrl_test.sv ***
`include "audio_fifo_consts.svh"
`default_nettype none

module audio_fifo_dma_wake_flush_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   import audio_fifo_pkg::*;
   // ----------------------------
   // Signals and instances
   // ----------------------------
   logic clk_sys, rst, wr_en, rd_en, pop_req, push_req, off;
   logic tx_pop, rx_push, tx_dma_req, rx_dma_req, dma_wake_req, irq;
   addr_t addr;
   word_t wr_data, rx_word, rd_data, tx_word, d;
   int num_errors, checked;
   audio_fifo_dma_wake_flush_ctrl dut (.clk_sys(clk_sys), .rst(rst), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .tx_pop(tx_pop),
      .tx_word(tx_word), .rx_push(rx_push), .rx_word(rx_word), .tx_dma_req(tx_dma_req),
      .rx_dma_req(rx_dma_req), .dma_wake_req(dma_wake_req), .irq(irq));
   link_model model (.clk_sys(clk_sys), .rst(rst), .pop_req(pop_req), .push_req(push_req),
      .tx_pop(tx_pop), .rx_push(rx_push), .rx_word(rx_word));
   // Clock
   always #20 clk_sys = ~clk_sys;
   // ----------------------------
   // Tasks
   // ----------------------------
   task automatic chk(input word_t seen, input word_t exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic chkb(input logic seen, input logic exp);
      chk({31'h0, seen}, {31'h0, exp});
   endtask
   task automatic test_done;
      $display("errors=%0d checks=%0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      if (!off) begin
         wr_en <= 1'b0;
      end
      repeat (n) @(posedge clk_sys);
      #1;
      off = 1'b1;
   endtask
   task automatic wr(input addr_t a, input word_t v);
      if (off) @(posedge clk_sys);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      rd_en <= 1'b0;
      @(posedge clk_sys);
      off = 1'b0;
   endtask
   task automatic rd(input addr_t a);
      if (off) @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      wr_en <= 1'b0;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
      off = 1'b1;
   endtask
   task automatic strm(input logic p, input int n);
      if (off) @(posedge clk_sys);
      pop_req <= p;
      push_req <= !p;
      wr_en <= 1'b0;
      repeat (n) @(posedge clk_sys);
      pop_req <= 1'b0;
      push_req <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      off = 1'b1;
   endtask
   // Watchdog
   initial begin
      repeat (3000) @(posedge clk_sys);
      num_errors++;
      test_done;
   end
   // ----------------------------
   // Tests
   // ----------------------------
   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      addr = 12'h000;
      wr_data = 32'h0000_0000;
      wr_en = 1'b0;
      rd_en = 1'b0;
      pop_req = 1'b0;
      push_req = 1'b0;
      off = 1'b1;
      num_errors = 0;
      checked = 0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      // Transmit requests up to a full FIFO
      rd(`CFG_OFS);
      chk(d, `WORD_ZERO);
      chkb(tx_dma_req, 1'b0);
      wr(`CFG_OFS, 32'h0000_1000);
      idle(1);
      chkb(tx_dma_req, 1'b1);
      for (int i = 0; i < `FIFO_DEPTH; i++) begin
         wr(`TX_DATA_OFS, 32'h0000_0100 + i);
      end
      idle(1);
      chkb(tx_dma_req, 1'b0);
      rd(`STAT_OFS);
      chk(d, 32'h0000_0800);
      strm(1'b1, 1);
      chk(tx_word, 32'h0000_0100);
      chkb(tx_dma_req, 1'b1);
      $display("test tx_dma done");
      // Flush by one, no flush by zero
      wr(`CFG_OFS, 32'h0001_1000);
      rd(`STAT_OFS);
      chk(d, 32'h0000_0030);
      rd(`CFG_OFS);
      chk(d, 32'h0000_1000);
      for (int i = 1; i < 4; i++) begin
         wr(`TX_DATA_OFS, 32'h0000_0000 + i);
      end
      wr(`CFG_OFS, 32'h0000_1000);
      rd(`STAT_OFS);
      chk(d, 32'h0000_0320);
      $display("test flush done");
      // Level wake per direction
      wr(`TRIG_OFS, 32'h0002_0300);
      wr(`CFG_OFS, 32'h0000_4000);
      idle(2);
      chkb(dma_wake_req, 1'b1);
      chkb(irq, 1'b0);
      chkb(tx_dma_req, 1'b0);
      wr(`CFG_OFS, 32'h0000_0000);
      idle(2);
      chkb(dma_wake_req, 1'b0);
      wr(`CFG_OFS, 32'h0000_a000);
      idle(2);
      chkb(dma_wake_req, 1'b0);
      chkb(rx_dma_req, 1'b0);
      strm(1'b0, 2);
      chkb(rx_dma_req, 1'b1);
      chkb(dma_wake_req, 1'b1);
      rd(`RX_DATA_OFS);
      chk(d, 32'h0000_a000);
      idle(1);
      chkb(dma_wake_req, 1'b0);
      wr(`CFG_OFS, 32'h0002_2000);
      rd(`STAT_OFS);
      chk(d, 32'h0000_0320);
      idle(1);
      chkb(rx_dma_req, 1'b0);
      strm(1'b0, 1);
      wr(`CFG_OFS, 32'h0000_0000);
      idle(1);
      chkb(rx_dma_req, 1'b0);
      $display("test wake rx done");
      // Error interrupt, mask, clear, unmapped place
      wr(`CFG_OFS, 32'h0001_0000);
      strm(1'b1, 1);
      chkb(irq, 1'b0);
      wr(`IRQ_MASK_OFS, 32'h0000_0001);
      idle(1);
      chkb(irq, 1'b1);
      wr(`IRQ_STAT_OFS, 32'h0000_0001);
      idle(1);
      chkb(irq, 1'b0);
      wr(12'he40, 32'hffff_ffff);
      rd(12'he40);
      chk(d, `WORD_ZERO);
      rd(`CFG_OFS);
      chk(d, `WORD_ZERO);
      wr(`TRIG_OFS, 32'h0002_0001);
      wr(`IRQ_MASK_OFS, 32'h0000_0004);
      idle(1);
      chkb(irq, 1'b1);
      rd(`IRQ_STAT_OFS);
      chk(d, 32'h0000_0004);
      $display("test irq done");
      test_done;
   end
endmodule

`default_nettype wire
